// [dv/blio_host_model.sv]
`timescale 1ns/10ps
module blio_host_model
    import blio_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_oe,
    output blio_bus_t        o_bus,
    output logic [15:0]      o_bus_level
);
    initial begin
        o_bus = '0;
        o_bus_level = BLIO_BUS_RESET;
    end
    // Four cycles up and four down clear the two synchroniser stages and the read register.
    task automatic access(input logic io, wr, input logic [15:0] a, d, output logic [15:0] rd,
                          output logic oe);
        o_bus = {io, wr, !wr, a, d};
        repeat (4) @(posedge i_mclk);
        #5 rd = i_rdata;
        oe = i_oe;
        o_bus = {3'b000, a, d};
        if (io) o_bus_level = wr ? d : rd;
        repeat (4) @(posedge i_mclk);
        #5;
    endtask
endmodule

// [dv/blio_ports_sva.sv]
`timescale 1ns/10ps
module blio_ports_sva
    import blio_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire blio_bus_t    i_bus,
    input  wire logic [15:0]  i_data_bus_in,
    input  wire blio_status_t i_status,
    input  wire logic [7:0]   i_switch_bank,
    input  wire logic [15:0]  o_rdata,
    input  wire logic         o_rdata_oe,
    input  wire logic [7:0]   o_lamps,
    input  wire logic         o_flag_lamp,
    input  wire logic         o_branch_lamp
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    wire logic io = i_bus.io_space_strobe;
    wire logic lw = io && i_bus.write_strobe && i_bus.addr == BLIO_LAMP_ADDR;
    wire logic sr = io && i_bus.read_strobe && i_bus.addr == BLIO_SWITCH_ADDR;
    wire logic lr = io && i_bus.read_strobe && i_bus.addr == BLIO_LAMP_ADDR;
    lamp_load_a: assert property ($rose(lw) |-> ##4 o_lamps == $past(i_bus.wdata[7:0], 4))
        else $error("lamp latch missed a write");
    lamp_hold_a: assert property (!$stable(o_lamps) |-> $past(lw, 4) && !$past(lw, 5))
        else $error("lamps changed without a lamp write");
    flag_lamp_a: assert property ($changed(i_status.external_flag_output) |->
        ##3 o_flag_lamp == $past(i_status.external_flag_output, 3))
        else $error("flag lamp wrong");
    branch_lamp_a: assert property ($changed(i_status.branch_test_input) |->
        ##3 o_branch_lamp == $past(i_status.branch_test_input, 3))
        else $error("branch lamp wrong");
    switch_read_a: assert property ($rose(sr) |-> ##4 o_rdata == {8'h00, i_switch_bank})
        else $error("switch read wrong");
    lamp_read_a: assert property ($rose(lr) |-> ##3 o_rdata == i_data_bus_in)
        else $error("lamp read not the bus value");
    drive_cause_a: assert property ($rose(o_rdata_oe) |-> $past(io && i_bus.read_strobe, 2))
        else $error("bus driven without an io read");
    space_only_a: assert property (!io [*3] |-> !o_rdata_oe)
        else $error("bus driven outside io space");
endmodule
bind blio_ports blio_ports_sva chk (.*);

// [dv/blio_ports_tb.sv]
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module blio_ports_tb import blio_pkg::*;;
    logic         i_mclk = 0;
    logic         i_rst = 1;
    blio_bus_t    bus;
    blio_status_t st;
    logic [15:0]  lvl, rd, rdata, d, eb, a;
    logic [7:0]   sw, lamps, el;
    logic         oe, fl, bl, oe_seen;
    int           errors = 0;
    int           checks = 0;
    always #50 i_mclk = ~i_mclk;
    blio_ports uut (.i_mclk, .i_rst, .i_bus(bus), .i_data_bus_in(lvl), .i_status(st),
        .i_switch_bank(sw), .o_rdata(rdata), .o_rdata_oe(oe), .o_lamps(lamps),
        .o_flag_lamp(fl), .o_branch_lamp(bl));
    blio_host_model host (.i_mclk, .i_rdata(rdata), .i_oe(oe), .o_bus(bus), .o_bus_level(lvl));
    task automatic print_verdict;
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000 errors++;
        print_verdict;
    end
    initial begin
        void'($urandom(57));
        sw = 0;
        st = 0;
        el = 0;
        eb = 0;
        repeat (2) @(posedge i_mclk);
        #5 i_rst = 0;
        for (int k = 0; k < 32; k++) begin
            d = $urandom;
            a = k[0] ? BLIO_SWITCH_ADDR : BLIO_LAMP_ADDR;
            sw = k[3] ? 8'hFF : 8'($urandom);
            st = 2'($urandom);
            host.access(k[1], k[2], a, d, rd, oe_seen);
            `CHK("oe", k[1] && !k[2], oe_seen)
            `CHK("oe_idle", 1'b0, oe)
            if (k[1] && !k[2]) `CHK("rdata", a == BLIO_SWITCH_ADDR ? {8'h00, sw} : eb, rd)
            if (k[1] && k[2] && !k[0]) el = d[7:0];
            if (k[1]) eb = k[2] ? d : a == BLIO_SWITCH_ADDR ? {8'h00, sw} : eb;
            `CHK("lamps", el, lamps)
            `CHK("flag", st.external_flag_output, fl)
            `CHK("branch", st.branch_test_input, bl)
        end
        print_verdict;
    end
endmodule

// [verilog/blio_pkg.sv]
package blio_pkg;

    localparam int             BLIO_ADDR_W        = 16;
    localparam int             BLIO_DATA_W        = 16;
    localparam int             BLIO_PORT_W        = 8;

    // I/O-space addresses of the two board ports.
    localparam logic [15:0]    BLIO_SWITCH_ADDR   = 16'h0008;
    localparam logic [15:0]    BLIO_LAMP_ADDR     = 16'h000C;

    localparam logic [7:0]     BLIO_LAMP_RESET    = 8'h00;
    localparam logic [15:0]    BLIO_BUS_RESET     = 16'h0000;
    // Upper data bits returned with an eight-bit port value.
    localparam logic [7:0]     BLIO_UPPER_PAD     = 8'h00;

    // One sampled external bus cycle from the processor.
    typedef struct packed {
        logic                  io_space_strobe;
        logic                  write_strobe;
        logic                  read_strobe;
        logic [15:0]           addr;
        logic [15:0]           wdata;
    } blio_bus_t;

    // Processor status pins that drive the two dedicated lamps.
    typedef struct packed {
        logic                  external_flag_output;
        logic                  branch_test_input;
    } blio_status_t;

endpackage

// [verilog/blio_ports.sv]
`timescale 1ns/10ps
// Summary of operation
// - An I/O write to address 000Ch loads the low eight data bits into the lamp latch.
// - Each lamp follows its own latched bit, lit for 1 and dark for 0.
// - The lamp latch is write-only; a read of 000Ch returns the last value seen on the data bus.
// - An I/O read of address 0008h drives the eight switch states onto the low data bits.
// - A switch that is on reads as 1 and off as 0, so all on reads as 00FFh.
// - The switch port is read-only; writes to its address change nothing.
// - A dedicated lamp is lit while the external flag output is 1.
// - A dedicated lamp is lit while the branch test input is 1.
module blio_ports
    import blio_pkg::*;
#(
    parameter int                       ADDR_W = BLIO_ADDR_W,
    parameter int                       DATA_W = BLIO_DATA_W,
    parameter int                       PORT_W = BLIO_PORT_W
)
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst,
    input  wire blio_bus_t              i_bus,
    input  wire logic [15:0]            i_data_bus_in,
    input  wire blio_status_t           i_status,
    input  wire logic [7:0]             i_switch_bank,
    output logic [15:0]                 o_rdata,
    output logic                        o_rdata_oe,
    output logic [7:0]                  o_lamps,
    output logic                        o_flag_lamp,
    output logic                        o_branch_lamp
);

    // Processor strobes come from the processor's own clock tree, and switches and
    // status pins are asynchronous, so every input passes two flip-flops first.
    blio_bus_t              bus_meta;
    blio_bus_t              bus_sync;
    logic [15:0]            dbus_meta;
    logic [15:0]            dbus_sync;
    blio_status_t           stat_meta;
    blio_status_t           stat_sync;
    logic [7:0]             sw_meta;
    logic [7:0]             sw_sync;
    logic [7:0]             switch_bank_register;
    logic [7:0]             lamp_output_latch;
    logic [15:0]            bus_hold;
    logic                   wr_seen;
    logic                   lamp_wr;
    logic                   sw_rd;
    logic                   lamp_rd;
    logic                   lamp_wr_first;

    // The decoder and both ports are sized for the board bus; any other width
    // would cut addresses or data without notice, so it is refused here.
    if (ADDR_W != BLIO_ADDR_W || DATA_W != BLIO_DATA_W || PORT_W != BLIO_PORT_W) begin
        $error("blio_ports only serves the board bus and port widths");
    end

    function automatic logic io_hit(input blio_bus_t b, input logic [15:0] a);
        io_hit = b.io_space_strobe && (b.addr == a);
    endfunction

    // Program-space and data-space cycles at the same address never match.
    function automatic logic io_write(input blio_bus_t b, input logic [15:0] a);
        io_write = io_hit(b, a) && b.write_strobe;
    endfunction

    function automatic logic io_read(input blio_bus_t b, input logic [15:0] a);
        io_read = io_hit(b, a) && b.read_strobe;
    endfunction

    // Widens a port value onto the data bus with the upper byte held low.
    function automatic logic [15:0] port_to_bus(input logic [7:0] v);
        port_to_bus = {BLIO_UPPER_PAD, v};
    endfunction

    // Each field of the bus word is synchronised on its own, so a strobe may be
    // seen one cycle apart from its address; the host holds all of them for
    // several cycles, which keeps the decode stable while it is used.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            bus_meta <= '0;
            bus_sync <= '0;
        end else begin
            bus_meta <= i_bus;
            bus_sync <= bus_meta;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dbus_meta <= BLIO_BUS_RESET;
            dbus_sync <= BLIO_BUS_RESET;
        end else begin
            dbus_meta <= i_data_bus_in;
            dbus_sync <= dbus_meta;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            stat_meta <= '0;
            stat_sync <= '0;
        end else begin
            stat_meta <= i_status;
            stat_sync <= stat_meta;
        end
    end

    // Switches bounce; the two stages only guard against metastability and do
    // not debounce, so a read during a bounce may return either level.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sw_meta <= '0;
            sw_sync <= '0;
        end else begin
            sw_meta <= i_switch_bank;
            sw_sync <= sw_meta;
        end
    end

    assign lamp_wr = io_write(bus_sync, BLIO_LAMP_ADDR);
    assign sw_rd   = io_read(bus_sync, BLIO_SWITCH_ADDR);
    assign lamp_rd = io_read(bus_sync, BLIO_LAMP_ADDR);

    // Loading only on the first strobe cycle keeps a long write from picking up
    // data that the host may already be changing at its end.
    assign lamp_wr_first = lamp_wr && !wr_seen;

    // A write strobe is seen once per access; the latch loads on its first cycle.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wr_seen <= 1'b0;
        end else begin
            wr_seen <= bus_sync.write_strobe;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            lamp_output_latch <= BLIO_LAMP_RESET;
        end else if (lamp_wr_first) begin
            lamp_output_latch <= bus_sync.wdata[BLIO_PORT_W-1:0];
        end
    end

    // Switch bits map one to one; no write path reaches them.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            switch_bank_register <= '0;
        end else begin
            switch_bank_register <= sw_sync;
        end
    end

    // Tracks the last value on the external data bus, which is what a read of the
    // write-only lamp address returns, as the board bus keeps its last level.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            bus_hold <= BLIO_BUS_RESET;
        end else if (bus_sync.write_strobe) begin
            bus_hold <= bus_sync.wdata;
        end else if (sw_rd) begin
            bus_hold <= port_to_bus(switch_bank_register);
        end else if (!(bus_sync.read_strobe && bus_sync.io_space_strobe)) begin
            bus_hold <= dbus_sync;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= BLIO_BUS_RESET;
        end else if (sw_rd) begin
            o_rdata <= port_to_bus(switch_bank_register);
        end else if (lamp_rd) begin
            o_rdata <= bus_hold;
        end
    end

    assign o_rdata_oe = sw_rd || lamp_rd;

    // The lamp drivers are registered so that no decode glitch reaches a lamp.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_lamps <= BLIO_LAMP_RESET;
        end else begin
            o_lamps <= lamp_output_latch;
        end
    end

    // The status lamps trail their pins by three cycles, far below what an eye sees.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_flag_lamp <= 1'b0;
        end else begin
            o_flag_lamp <= stat_sync.external_flag_output;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_branch_lamp <= 1'b0;
        end else begin
            o_branch_lamp <= stat_sync.branch_test_input;
        end
    end

endmodule
